// *** hdl/tms_maint_sync.sv ***
// Translation-buffer maintenance and sync control for a translation unit.
// Assumes register decode outside turns writes into one-cycle strobes with
// an operation code and operand; the buffer reports retirement per source.
// Functional notes
// - Broadcast support is reported by an identification bit.
// - With private VM hint set, broadcasts naming a VMID may be dropped.
// - Broadcast non-secure guest invalidate-all is always honoured; a register invalidate in the same cycle drops it.
// - Private VM hint leaves secure broadcasts untouched.
// - Per-bank private AS hint lets broadcasts naming an ASID be dropped.
// - Bank writes to six stage 1 registers start invalidations.
// - Bank writes to two stage 2 registers start invalidations.
// - Bank sync write starts a sync; status shows active until done; bank status still reads idle in the cycle after the write.
// - Global writes to eleven registers start unit-wide invalidations.
// - Global sync covers its security state including its banks.
// - Global status completes once all earlier invalidations finish.
// - Posting writes are confirmed only by a later sync.
// - Invalidation done only when entries gone and users observed.
// - Nested stage 1 fetch counts as one transaction for stage 2.
// - Invalidation posts are always accepted, independent of traffic; a global post in the same cycle as a bank post is not issued.
// - Bank sync guarantees only that bank's invalidations.
// - Global sync guarantees its state's global and bank invalidations; secure covers all banks.
// - Global state is kept separately per security state.
// - Each context bank has independent tracking state.
`timescale 1ns/100ps
module tms_maint_sync
  import tms_pkg::*;
#(
  parameter int NUM_BANKS = 4,
  parameter int BANK_W = 2,
  parameter int OPND_W = 64,
  parameter bit BCAST_SUPPORTED = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  // Context bank register strobes.
  input wire logic cbWrite,
  input wire logic [BANK_W-1:0] cbIndex,
  input wire logic [3:0] cbOp,
  input wire logic [OPND_W-1:0] cbData,
  input wire logic [NUM_BANKS-1:0] bankSecure,
  input wire logic [NUM_BANKS-1:0] private_as_namespace_hint,
  // Global register strobes; secure selects the banked copy.
  input wire logic gWrite,
  input wire logic gSecure,
  input wire logic [3:0] gOp,
  input wire logic [OPND_W-1:0] gData,
  input wire logic private_vm_namespace_hint,
  // Broadcast maintenance messages from the interconnect.
  input wire logic bcValid,
  input wire logic [1:0] bcOp,
  input wire logic [BANK_W-1:0] bcBank,
  input wire logic [OPND_W-1:0] bcData,
  // Invalidate command to the translation buffer.
  output logic invValid,
  output logic [1:0] invSource,
  output logic [3:0] invOp,
  output logic [BANK_W-1:0] invBank,
  output logic invSecure,
  output logic [OPND_W-1:0] invOperand,
  // Retirement reports from the buffer: entries gone and users observed.
  input wire logic cbDone,
  input wire logic [BANK_W-1:0] cbDoneBank,
  input wire logic gDone,
  input wire logic gDoneSecure,
  // Status views.
  output logic broadcast_maint_supported,
  output logic [NUM_BANKS-1:0] cb_sync_state,
  output logic [1:0] global_sync_state
);
  logic [NUM_BANKS-1:0] bankSyncActive;
  logic [NUM_BANKS-1:0] bankIdle;
  logic [1:0] gSyncActive;
  logic [1:0] gIdle;
  logic [1:0] gSyncOpen;
  logic [1:0] gRelease;
  logic bcKeep;
  logic cbInv;
  logic gInv;
  logic gSyncHit;

  // Decodes an invalidate operation code from the bank space.
  function automatic logic cb_is_inv(input logic [3:0] op);
    cb_is_inv = (op <= TMS_CB_INV_IPA_LEAF);
  endfunction

  // Decodes an invalidate operation code from the global space.
  function automatic logic g_is_inv(input logic [3:0] op);
    g_is_inv = (op <= TMS_G_VM_FIRST_STAGE);
  endfunction

  assign cbInv = cbWrite && cb_is_inv(cbOp);
  assign gInv = gWrite && g_is_inv(gOp);
  assign gSyncHit = gWrite && (gOp == TMS_G_SYNC);

  ////////////////////////////////////////////////////////////////////////////
  // Broadcast filter. The VM hint only drops by-VM messages; the guest
  // invalidate-all and secure messages pass regardless.
  always_comb begin
    bcKeep = bcValid && BCAST_SUPPORTED;
    unique case (bcOp)
      TMS_BC_BY_VM: begin
        if (private_vm_namespace_hint) begin
          bcKeep = 1'b0;
        end
      end
      TMS_BC_BY_AS: begin
        if (private_as_namespace_hint[bcBank]) begin
          bcKeep = 1'b0;
        end
      end
      TMS_BC_NS_GUEST_ALL: begin
        bcKeep = bcValid && BCAST_SUPPORTED;
      end
      TMS_BC_SECURE: begin
        bcKeep = bcValid && BCAST_SUPPORTED;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command issue. Posts never wait on client traffic; the buffer must take
  // one command per cycle. Register posts win over broadcast in a clash.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      invValid <= 1'b0;
      invSource <= TMS_SRC_CB;
      invOp <= 4'h0;
      invBank <= '0;
      invSecure <= 1'b0;
      invOperand <= '0;
    end else begin
      invValid <= cbInv || gInv || bcKeep;
      if (cbInv) begin
        invSource <= TMS_SRC_CB;
        invOp <= cbOp;
        invBank <= cbIndex;
        invSecure <= bankSecure[cbIndex];
        invOperand <= cbData;
      end else if (gInv) begin
        invSource <= TMS_SRC_GLOBAL;
        invOp <= gOp;
        invBank <= '0;
        invSecure <= gSecure;
        invOperand <= gData;
      end else if (bcKeep) begin
        invSource <= TMS_SRC_BCAST;
        invOp <= {2'b00, bcOp};
        invBank <= bcBank;
        invSecure <= (bcOp == TMS_BC_SECURE);
        invOperand <= bcData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One tracker per bank; a bank sync waits only on its own posts.
  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      tms_sync_tracker u_trk (
        .clk(clk),
        .rst_b(rst_b),
        .issue(cbInv && cbIndex == BANK_W'(b)),
        .done(cbDone && cbDoneBank == BANK_W'(b)),
        .syncReq(cbWrite && cbOp == TMS_CB_SYNC && cbIndex == BANK_W'(b)),
        .syncActive(bankSyncActive[b]),
        .idle(bankIdle[b])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Global trackers banked by security state. A global sync also waits
  // for banks of its state (secure covers all banks); bank posts made
  // after the sync are covered too, a conservative but safe reading.
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_sec
      logic banksQuiet;
      always_comb begin
        banksQuiet = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++) begin
          if (!bankIdle[i] && (s == 1 || !bankSecure[i])) begin
            banksQuiet = 1'b0;
          end
        end
      end
      tms_sync_tracker u_gtrk (
        .clk(clk),
        .rst_b(rst_b),
        .issue(gInv && gSecure == 1'(s)),
        .done(gDone && gDoneSecure == 1'(s)),
        .syncReq(gSyncHit && gSecure == 1'(s)),
        .syncActive(gSyncActive[s]),
        .idle(gIdle[s])
      );
      assign gRelease[s] = !gSyncActive[s] && banksQuiet;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gSyncOpen <= 2'b00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (gSyncHit && gSecure == 1'(k)) begin
          gSyncOpen[k] <= 1'b1;
        end else if (gSyncOpen[k] && gRelease[k]) begin
          gSyncOpen[k] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs, all registered.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      broadcast_maint_supported <= 1'b0;
      cb_sync_state <= '0;
      global_sync_state <= 2'b00;
    end else begin
      broadcast_maint_supported <= BCAST_SUPPORTED;
      cb_sync_state <= bankSyncActive;
      global_sync_state <= gSyncOpen | {gSecure, !gSecure} &
                           {2{gSyncHit}};
    end
  end

  property p_vm_drop;
    @(posedge clk) disable iff (!rst_b)
      (bcValid && bcOp == TMS_BC_BY_VM && private_vm_namespace_hint &&
       !cbInv && !gInv) |=> !invValid;
  endproperty
  a_vm_drop: assert property (p_vm_drop)
    else $error("by-VM broadcast issued despite private hint");

  property p_guest_all;
    @(posedge clk) disable iff (!rst_b)
      (bcValid && bcOp == TMS_BC_NS_GUEST_ALL && BCAST_SUPPORTED)
      |=> invValid;
  endproperty
  a_guest_all: assert property (p_guest_all)
    else $error("guest invalidate-all broadcast lost");

  property p_secure_bc;
    @(posedge clk) disable iff (!rst_b)
      (bcValid && bcOp == TMS_BC_SECURE && BCAST_SUPPORTED)
      |=> invValid;
  endproperty
  a_secure_bc: assert property (p_secure_bc)
    else $error("secure broadcast dropped");

  property p_as_drop;
    @(posedge clk) disable iff (!rst_b)
      (bcValid && bcOp == TMS_BC_BY_AS && private_as_namespace_hint[bcBank]
       && !cbInv && !gInv) |=> !invValid;
  endproperty
  a_as_drop: assert property (p_as_drop)
    else $error("by-AS broadcast issued despite private hint");

  property p_cb_post;
    @(posedge clk) disable iff (!rst_b)
      cbInv |=> (invValid && invSource == TMS_SRC_CB &&
                 invOperand == $past(cbData));
  endproperty
  a_cb_post: assert property (p_cb_post)
    else $error("bank invalidate not issued with its operand");

  property p_g_post;
    @(posedge clk) disable iff (!rst_b)
      (gInv && !cbInv) |=> (invValid && invSource == TMS_SRC_GLOBAL &&
                            invSecure == $past(gSecure));
  endproperty
  a_g_post: assert property (p_g_post)
    else $error("global invalidate not issued");

  property p_cb_sync_shown;
    @(posedge clk) disable iff (!rst_b)
      (cbWrite && cbOp == TMS_CB_SYNC) |=> ##1 cb_sync_state[$past(cbIndex,2)];
  endproperty
  a_cb_sync_shown: assert property (p_cb_sync_shown)
    else $error("bank sync not shown active");

  property p_g_sync_shown;
    @(posedge clk) disable iff (!rst_b)
      gSyncHit |=> global_sync_state[$past(gSecure)];
  endproperty
  a_g_sync_shown: assert property (p_g_sync_shown)
    else $error("global sync not shown active");

  property p_g_wait_banks;
    @(posedge clk) disable iff (!rst_b)
      (gSyncOpen[1] && bankIdle != {NUM_BANKS{1'b1}}) |=> gSyncOpen[1];
  endproperty
  a_g_wait_banks: assert property (p_g_wait_banks)
    else $error("secure global sync ended with bank work pending");

  property p_id_bit;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) |-> (broadcast_maint_supported == BCAST_SUPPORTED);
  endproperty
  a_id_bit: assert property (p_id_bit)
    else $error("identification bit differs from the build option");

  property p_cb_fields;
    @(posedge clk) disable iff (!rst_b)
      cbInv |=> (invOp == $past(cbOp) && invBank == $past(cbIndex));
  endproperty
  a_cb_fields: assert property (p_cb_fields)
    else $error("bank invalidate issued with wrong code or bank");

  property p_cb_secure;
    @(posedge clk) disable iff (!rst_b)
      cbInv |=> (invSecure == $past(bankSecure[cbIndex]));
  endproperty
  a_cb_secure: assert property (p_cb_secure)
    else $error("bank invalidate issued with wrong security state");

  property p_g_fields;
    @(posedge clk) disable iff (!rst_b)
      (gInv && !cbInv) |=> (invOp == $past(gOp) &&
                            invOperand == $past(gData));
  endproperty
  a_g_fields: assert property (p_g_fields)
    else $error("global invalidate issued without its operand");

  property p_bc_fields;
    @(posedge clk) disable iff (!rst_b)
      (bcKeep && !cbInv && !gInv) |=> (invSource == TMS_SRC_BCAST &&
        invSecure == $past(bcOp == TMS_BC_SECURE) &&
        invOperand == $past(bcData));
  endproperty
  a_bc_fields: assert property (p_bc_fields)
    else $error("broadcast issued with wrong fields");

  property p_sync_no_cmd;
    @(posedge clk) disable iff (!rst_b)
      (!cbInv && !gInv && !bcKeep) |=> !invValid;
  endproperty
  a_sync_no_cmd: assert property (p_sync_no_cmd)
    else $error("command issued without an invalidate post");

  // A non-secure sync must not end while a non-secure bank still works.
  property p_ns_wait_banks;
    @(posedge clk) disable iff (!rst_b)
      (gSyncOpen[0] && (bankIdle | bankSecure) != {NUM_BANKS{1'b1}})
      |=> gSyncOpen[0];
  endproperty
  a_ns_wait_banks: assert property (p_ns_wait_banks)
    else $error("non-secure global sync ended with bank work pending");
endmodule

// *** hdl/tms_pkg.sv ***
// Package for the translation-buffer maintenance and sync block.
// Assumes a single clock domain; shared by the top and the bank tracker.
package tms_pkg;
  // Context bank operation codes, one per maintenance register.
  typedef enum logic [3:0] {
    TMS_CB_INV_ALL = 4'h0,
    TMS_CB_INV_AS = 4'h1,
    TMS_CB_INV_ADDR = 4'h2,
    TMS_CB_INV_ADDR_ANY_AS = 4'h3,
    TMS_CB_INV_ADDR_ANY_AS_LEAF = 4'h4,
    TMS_CB_INV_ADDR_LEAF = 4'h5,
    TMS_CB_INV_IPA = 4'h6,
    TMS_CB_INV_IPA_LEAF = 4'h7,
    TMS_CB_SYNC = 4'h8
  } tms_cb_op_t;
  // Global space operation codes.
  typedef enum logic [3:0] {
    TMS_G_SEC_ALL = 4'h0,
    TMS_G_SEC_MON_ALL = 4'h1,
    TMS_G_HYP_ALL = 4'h2,
    TMS_G_NS_GUEST_ALL = 4'h3,
    TMS_G_SEC_MON_ADDR_LEAF = 4'h4,
    TMS_G_SEC_MON_ADDR = 4'h5,
    TMS_G_HYP_ADDR = 4'h6,
    TMS_G_HYP_ADDR_WIDE = 4'h7,
    TMS_G_HYP_ADDR_LEAF_WIDE = 4'h8,
    TMS_G_BY_VM = 4'h9,
    TMS_G_VM_FIRST_STAGE = 4'hA,
    TMS_G_SYNC = 4'hB
  } tms_g_op_t;
  // Broadcast message kinds.
  typedef enum logic [1:0] {
    TMS_BC_NS_GUEST_ALL = 2'h0,
    TMS_BC_BY_VM = 2'h1,
    TMS_BC_BY_AS = 2'h2,
    TMS_BC_SECURE = 2'h3
  } tms_bc_op_t;
  // Kind field of the invalidate command issued to the translation buffer.
  localparam logic [1:0] TMS_SRC_CB = 2'h0;
  localparam logic [1:0] TMS_SRC_GLOBAL = 2'h1;
  localparam logic [1:0] TMS_SRC_BCAST = 2'h2;
  localparam int TMS_CNT_W = 8;
  localparam logic [TMS_CNT_W-1:0] TMS_CNT_ZERO = 8'h00;
  localparam logic [TMS_CNT_W-1:0] TMS_CNT_ONE = 8'h01;
  localparam int TMS_STATUS_ACTIVE_BIT = 0;
endpackage

// *** hdl/tms_sync_tracker.sv ***
// Sync tracker for one invalidation resource (a bank or a security state).
// Assumes issue and done pulses come from logic on the same clock.
`timescale 1ns/100ps
module tms_sync_tracker
  import tms_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic issue,
  input wire logic done,
  input wire logic syncReq,
  output logic syncActive,
  output logic idle
);
  logic [TMS_CNT_W-1:0] outstanding;
  logic [TMS_CNT_W-1:0] pending;
  logic [TMS_CNT_W-1:0] next_outstanding;

  ////////////////////////////////////////////////////////////////////////////
  // Issue and retire may meet in one cycle; both are counted.
  always_comb begin
    next_outstanding = outstanding;
    if (issue && !done) begin
      next_outstanding = outstanding + TMS_CNT_ONE;
    end else if (done && !issue && outstanding != TMS_CNT_ZERO) begin
      next_outstanding = outstanding - TMS_CNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      outstanding <= TMS_CNT_ZERO;
    end else begin
      outstanding <= next_outstanding;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A sync snapshots only the work posted before it; later posts do not
  // extend it, so a steady stream of posts cannot starve the sync.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pending <= TMS_CNT_ZERO;
      syncActive <= 1'b0;
    end else if (syncReq) begin
      pending <= (done && outstanding != TMS_CNT_ZERO) ?
                 outstanding - TMS_CNT_ONE : outstanding;
      syncActive <= 1'b1;
    end else if (syncActive) begin
      if (pending == TMS_CNT_ZERO) begin
        syncActive <= 1'b0;
      end else if (done) begin
        pending <= pending - TMS_CNT_ONE;
      end
    end
  end

  assign idle = (outstanding == TMS_CNT_ZERO);

  property p_sync_clears;
    @(posedge clk) disable iff (!rst_b)
      (syncActive && pending == TMS_CNT_ZERO && !syncReq) |=> !syncActive;
  endproperty
  a_sync_clears: assert property (p_sync_clears)
    else $error("sync stayed active with nothing pending");

  property p_sync_holds;
    @(posedge clk) disable iff (!rst_b)
      (syncActive && pending > TMS_CNT_ONE) |=> syncActive;
  endproperty
  a_sync_holds: assert property (p_sync_holds)
    else $error("sync ended with work still pending");
endmodule

// *** tb/tms_maint_sync_tb_top.sv ***
// Self-checking bench for the maintenance and sync block.
// Assumes the buffer side is played here: retirements are pulsed by hand.
`timescale 1ns/100ps
module tms_maint_sync_tb_top
  import tms_pkg::*;
;
  logic clk;
  logic rst_b;
  logic cbWrite;
  logic [1:0] cbIndex;
  logic [3:0] cbOp;
  logic [63:0] cbData;
  logic [3:0] bankSecure;
  logic [3:0] asHint;
  logic gWrite;
  logic gSecure;
  logic [3:0] gOp;
  logic [63:0] gData;
  logic vmHint;
  logic bcValid;
  logic [1:0] bcOp;
  logic [1:0] bcBank;
  logic [63:0] bcData;
  logic invValid;
  logic [1:0] invSource;
  logic [3:0] invOp;
  logic [1:0] invBank;
  logic invSecure;
  logic [63:0] invOperand;
  logic cbDone;
  logic [1:0] cbDoneBank;
  logic gDone;
  logic gDoneSecure;
  logic bcastSupported;
  logic [3:0] cbSyncState;
  logic [1:0] globalSyncState;
  int errors;
  int checks;
  int pulses;
  int base;
  logic [63:0] dat;
  int bcExp [3][4];

  tms_maint_sync i_tms_maint_sync (
    .clk(clk), .rst_b(rst_b), .cbWrite(cbWrite), .cbIndex(cbIndex),
    .cbOp(cbOp), .cbData(cbData), .bankSecure(bankSecure),
    .private_as_namespace_hint(asHint), .gWrite(gWrite),
    .gSecure(gSecure), .gOp(gOp), .gData(gData),
    .private_vm_namespace_hint(vmHint), .bcValid(bcValid), .bcOp(bcOp),
    .bcBank(bcBank), .bcData(bcData), .invValid(invValid),
    .invSource(invSource), .invOp(invOp), .invBank(invBank),
    .invSecure(invSecure), .invOperand(invOperand), .cbDone(cbDone),
    .cbDoneBank(cbDoneBank), .gDone(gDone), .gDoneSecure(gDoneSecure),
    .broadcast_maint_supported(bcastSupported),
    .cb_sync_state(cbSyncState), .global_sync_state(globalSyncState)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counting pulses at the edge lets the back-to-back test see every command.
  always @(posedge clk) begin
    if (rst_b === 1'b1 && invValid === 1'b1) begin
      pulses++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] exp,
                       input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One strobe for one cycle; src 0 bank, 1 global, 2 broadcast.
  task automatic post(input int src, input logic [3:0] op,
                      input logic [1:0] b, input logic s,
                      input logic [63:0] d);
    @(posedge clk);
    if (src == 0) begin
      cbWrite <= 1'b1;
      cbIndex <= b;
      cbOp <= op;
      cbData <= d;
    end else if (src == 1) begin
      gWrite <= 1'b1;
      gSecure <= s;
      gOp <= op;
      gData <= d;
    end else begin
      bcValid <= 1'b1;
      bcBank <= b;
      bcOp <= op[1:0];
      bcData <= d;
    end
    @(posedge clk);
    cbWrite <= 1'b0;
    gWrite <= 1'b0;
    bcValid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic checkCmd(input int src, input logic [3:0] op,
                          input logic [1:0] b, input logic s,
                          input logic [63:0] d);
    check("invValid", 1, invValid);
    check("invSource", src, invSource);
    check("invOperand", d, invOperand);
    check("invOp", op, invOp);
    check("invBank", (src == 1) ? 2'h0 : b, invBank);
    if (src == 0) begin
      check("invSecure", bankSecure[b], invSecure);
    end else if (src == 1) begin
      check("invSecure", s, invSecure);
    end else begin
      check("invSecure", op[1:0] == TMS_BC_SECURE, invSecure);
    end
    @(negedge clk);
    check("invValid drop", 0, invValid);
  endtask

  task automatic retire(input bit glob, input logic [1:0] b, input logic s);
    @(posedge clk);
    if (glob) begin
      gDone <= 1'b1;
      gDoneSecure <= s;
    end else begin
      cbDone <= 1'b1;
      cbDoneBank <= b;
    end
    @(posedge clk);
    gDone <= 1'b0;
    cbDone <= 1'b0;
    @(negedge clk);
  endtask

  // Polls like software does, but gives up after a bounded number of cycles.
  task automatic waitLow(input string nm, input bit glob, input int idx);
    int n;
    n = 0;
    while ((glob ? globalSyncState[idx] : cbSyncState[idx]) !== 1'b0
           && n < 8) begin
      @(negedge clk);
      n++;
    end
    check(nm, 0, glob ? globalSyncState[idx] : cbSyncState[idx]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    errors++;
    summarize();
  end

  initial begin
    rst_b = 1'b0;
    cbWrite = 1'b0;
    cbIndex = 2'h0;
    cbOp = 4'h0;
    cbData = 64'h0000_0000_0000_0000;
    bankSecure = 4'h8;
    asHint = 4'h0;
    gWrite = 1'b0;
    gSecure = 1'b0;
    gOp = 4'h0;
    gData = 64'h0000_0000_0000_0000;
    vmHint = 1'b0;
    bcValid = 1'b0;
    bcOp = 2'h0;
    bcBank = 2'h0;
    bcData = 64'h0000_0000_0000_0000;
    cbDone = 1'b0;
    cbDoneBank = 2'h0;
    gDone = 1'b0;
    gDoneSecure = 1'b0;
    bcExp = '{'{1, 1, 1, 1}, '{1, 0, 2, 1}, '{1, 1, 0, 1}};
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("reset invValid", 0, invValid);
    check("reset cbSyncState", 0, cbSyncState);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("bcastSupported", 1, bcastSupported);
    check("idle globalSyncState", 0, globalSyncState);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      dat = 64'h0000_0000_0000_1000 + 64'(i);
      post(0, i[3:0], i[1:0], 1'b0, dat);
      checkCmd(0, i[3:0], i[1:0], 1'b0, dat);
      retire(1'b0, i[1:0], 1'b0);
    end
    $display("test bank posts done");
    for (int i = 0; i < 11; i++) begin
      dat = 64'h0000_0000_0002_0000 + 64'(i);
      post(1, i[3:0], 2'h0, i[0], dat);
      checkCmd(1, i[3:0], 2'h0, i[0], dat);
      retire(1'b1, 2'h0, i[0]);
    end
    $display("test global posts done");
    // Bank 1 keeps one invalidate outstanding while three syncs are raised.
    post(0, 4'h2, 2'h1, 1'b0, 64'h0000_0000_0003_0000);
    post(0, 4'h8, 2'h1, 1'b0, 64'h0000_0000_0000_0000);
    post(0, 4'h8, 2'h2, 1'b0, 64'h0000_0000_0000_0000);
    post(1, 4'hB, 2'h0, 1'b0, 64'h0000_0000_0000_0000);
    repeat (8) @(negedge clk);
    check("bank1 sync held", 1, cbSyncState[1]);
    check("bank2 sync", 0, cbSyncState[2]);
    check("global ns sync held", 1, globalSyncState[0]);
    retire(1'b0, 2'h1, 1'b0);
    waitLow("bank1 sync", 1'b0, 1);
    waitLow("global ns sync", 1'b1, 0);
    $display("test bank sync done");
    post(1, 4'h0, 2'h0, 1'b1, 64'h0000_0000_0004_0000);
    post(1, 4'hB, 2'h0, 1'b0, 64'h0000_0000_0000_0000);
    post(1, 4'hB, 2'h0, 1'b1, 64'h0000_0000_0000_0000);
    repeat (8) @(negedge clk);
    check("ns sync apart", 0, globalSyncState[0]);
    check("secure sync held", 1, globalSyncState[1]);
    retire(1'b1, 2'h0, 1'b0);
    repeat (4) @(negedge clk);
    check("secure sync kept", 1, globalSyncState[1]);
    retire(1'b1, 2'h0, 1'b1);
    waitLow("secure sync", 1'b1, 1);
    // Secure bank 3 holds work: only the secure global sync waits on it.
    dat = 64'h0000_0000_0006_0000;
    post(0, 4'h0, 2'h3, 1'b0, dat);
    checkCmd(0, 4'h0, 2'h3, 1'b0, dat);
    post(1, 4'hB, 2'h0, 1'b0, 64'h0000_0000_0000_0000);
    post(1, 4'hB, 2'h0, 1'b1, 64'h0000_0000_0000_0000);
    repeat (8) @(negedge clk);
    check("ns sync free of secure bank", 0, globalSyncState[0]);
    check("secure sync waits on bank", 1, globalSyncState[1]);
    retire(1'b0, 2'h3, 1'b0);
    waitLow("secure sync after bank", 1'b1, 1);
    $display("test global sync done");
    for (int c = 0; c < 3; c++) begin
      @(posedge clk);
      vmHint <= (c == 1);
      asHint <= (c == 2) ? 4'h2 : 4'h0;
      for (int o = 0; o < 4; o++) begin
        if (bcExp[c][o] != 2) begin
          dat = 64'h0000_0000_0005_0000 + 64'(o);
          post(2, o[3:0], 2'h1, 1'b0, dat);
          if (bcExp[c][o] == 1) begin
            checkCmd(2, o[3:0], 2'h1, 1'b0, dat);
          end else begin
            check("bcast dropped", 0, invValid);
          end
        end
      end
    end
    $display("test broadcast done");
    // Posts on every cycle with no retirement must all be accepted.
    @(posedge clk);
    base = pulses;
    for (int i = 0; i < 16; i++) begin
      cbWrite <= 1'b1;
      cbIndex <= 2'h0;
      cbOp <= 4'(i % 8);
      cbData <= 64'(i);
      @(posedge clk);
    end
    cbWrite <= 1'b0;
    repeat (3) @(negedge clk);
    check("back to back count", 16, pulses - base);
    $display("test back to back done");
    summarize();
  end
endmodule
